// >>> regulator_supervisor_and_reset_control_tb.sv
/* bench for the supervisor: defaults, enables, faults, power good,
   warm reset, system reset hold. assumes rsrc_pkg, rsrc_top, rsrc_host. */
`timescale 1ns/10ps
module regulator_supervisor_and_reset_control_tb;
    logic                  pclk, presetn, psel, penable, pwrite, pready;
    logic                  pslverr, int_n, sys_rst_n, req_warm, uvlo;
    logic                  overtemperature, rtc_rail_low;
    logic                  system_reset_out_o, system_reset_out_oe;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, r, reset_delay_cap_pin;
    logic [3:0]            req_en;
    logic [2:0]            dsel;
    logic [4:0]            rail_on;
    logic [5:0]            buck3_vsel;
    logic [1:0]            buck12_default_hi;
    wire                   buck1_enable, buck2_enable, buck3_enable;
    wire                   linear_reg_enable_pin, warm_reset_n_in;
    rsrc_pkg::rsrc_sense_t sense;
    rsrc_pkg::rsrc_stage_t stage;
    int                    fails, n_tests, k;
    // offset beside expected read value; 0x00 is unmapped
    logic [39:0] rows [6] = '{{8'h08, 32'h0}, {8'h0c, 32'h0},
        {8'h10, 32'h0}, {8'h14, 32'h3}, {8'h20, 32'hd}, {8'h00, 32'hff}};

    rsrc_top #(.DELAY_CYC(4), .SOFT_CYC(8), .DEB_CYC(4), .HOLD_CYC(16))
    DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .buck1_enable(buck1_enable),
        .buck2_enable(buck2_enable), .buck3_enable(buck3_enable),
        .linear_reg_enable_pin(linear_reg_enable_pin),
        .buck1_default_select(dsel[0]), .buck2_default_select(dsel[1]),
        .buck3_default_select(dsel[2]), .uvlo(uvlo),
        .overtemperature(overtemperature), .rtc_rail_low(rtc_rail_low),
        .warm_reset_n_in(warm_reset_n_in),
        .reset_delay_cap_pin(reset_delay_cap_pin), .sense(sense),
        .stage(stage), .rail_on(rail_on), .buck3_vsel(buck3_vsel),
        .buck12_default_hi(buck12_default_hi), .int_n(int_n),
        .system_reset_out_o(system_reset_out_o),
        .system_reset_out_oe(system_reset_out_oe));
    rsrc_host u_host (.req_en(req_en), .req_warm(req_warm),
        .system_reset_out_o(system_reset_out_o),
        .system_reset_out_oe(system_reset_out_oe),
        .buck1_enable(buck1_enable), .buck2_enable(buck2_enable),
        .buck3_enable(buck3_enable),
        .linear_reg_enable_pin(linear_reg_enable_pin),
        .warm_reset_n_in(warm_reset_n_in), .sys_rst_n(sys_rst_n));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // cycles until the reset line lets go, bounded
    task automatic rel(input int lo);
        for (k = 0; sys_rst_n !== 1'b1 && k < 100; k++) @(posedge pclk);
        chk(k >= lo - 1 && k <= lo + 12, 1'b1);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // under two hundred cycles expected; far more means a hang
    initial begin
        #50000;
        fails++;
        print_verdict;
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, r} = '0;
        {uvlo, overtemperature, rtc_rail_low, req_warm, req_en} = '0;
        {reset_delay_cap_pin, sense, dsel, fails, n_tests} = '0;
        cyc(6);
        presetn <= 1'b1;
        cyc(1);
        chk(sys_rst_n, 1'b0);
        rel(16);
        foreach (rows[i]) begin
            apb(1'b0, rows[i][39:32], 32'h0);
            chk(r, rows[i][31:0]);
        end
        $display("test defaults done");
        rtc_rail_low <= 1'b1;
        cyc(4);
        chk(sys_rst_n, 1'b0);
        rtc_rail_low <= 1'b0;
        rel(16);
        dsel   <= 3'h3;
        req_en <= 4'hf;
        sense.precharged <= 3'h1;
        cyc(2);
        chk({rail_on, stage.switching}, 8'hf8);
        chk(buck12_default_hi, 2'h3);
        cyc(6);
        chk(stage.hold_off, 3'h1);
        sense.precharged <= 3'h0;
        cyc(3);
        chk(stage.hold_off, 3'h0);
        cyc(7);
        chk(stage.switching, 3'h7);
        apb(1'b1, rsrc_pkg::RSRC_OFF_CONV, 32'h8);
        sense.near_drop <= 3'h2;
        cyc(2);
        chk({stage.low_ripple, stage.full_duty}, 6'h3a);
        sense.out_low <= 5'h10;
        cyc(3);
        chk(int_n, 1'b0);
        apb(1'b0, rsrc_pkg::RSRC_OFF_PGOOD, 32'h0);
        chk(r[4:0], 5'h10);
        cyc(2);
        chk(int_n, 1'b1);
        apb(1'b1, rsrc_pkg::RSRC_OFF_CONV2, 32'h7);
        req_en <= 4'hb;
        cyc(3);
        chk(stage.discharge, 3'h4);
        apb(1'b0, rsrc_pkg::RSRC_OFF_PGOOD, 32'h0);
        chk(r[4:0], 5'h00);
        uvlo <= 1'b1;
        cyc(3);
        chk({rail_on, stage.discharge}, 8'h07);
        {uvlo, overtemperature} <= 2'b01;
        cyc(3);
        chk(rail_on, 5'h00);
        overtemperature <= 1'b0;
        $display("test rails done");
        dsel <= 3'h4;
        reset_delay_cap_pin <= 32'h0000_0020;
        apb(1'b1, rsrc_pkg::RSRC_OFF_BUCK3V, 32'h5);
        req_warm <= 1'b1;
        cyc(2);
        req_warm <= 1'b0;
        cyc(6);
        chk({sys_rst_n, buck3_vsel}, 7'h45);
        req_warm <= 1'b1;
        cyc(8);
        chk({sys_rst_n, buck3_vsel}, {1'b0, rsrc_pkg::RSRC_B3_HIGH});
        apb(1'b0, rsrc_pkg::RSRC_OFF_CONV, 32'h0);
        chk(r, 32'h8);
        req_warm <= 1'b0;
        rel(36);
        $display("test warm reset done");
        print_verdict;
    end
endmodule

// >>> rsrc_host.sv
/* host model: drives the enable pins and the warm reset request, and
   sees the open-drain system reset. assumes the bench drives req_*. */
`timescale 1ns/10ps
module rsrc_host (
    input  wire logic [3:0] req_en,
    input  wire logic       req_warm,
    input  wire logic       system_reset_out_o,
    input  wire logic       system_reset_out_oe,
    output logic            buck1_enable,
    output logic            buck2_enable,
    output logic            buck3_enable,
    output logic            linear_reg_enable_pin,
    output logic            warm_reset_n_in,
    output logic            sys_rst_n
);
    // pins follow the host at once, so any power-up order is possible
    assign buck1_enable          = req_en[0];
    assign buck2_enable          = req_en[1];
    assign buck3_enable          = req_en[2];
    assign linear_reg_enable_pin = req_en[3];
    assign warm_reset_n_in       = ~req_warm;
    // pull-up wins when released, so a stale low never lingers
    assign sys_rst_n = system_reset_out_oe ? system_reset_out_o : 1'b1;
endmodule

// >>> rsrc_pkg.sv
/*
 * Package for the regulator supervisor and reset control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz pclk and 32-bit APB data with word-aligned registers.
 */
package rsrc_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] RSRC_OFF_PGOOD   = 8'h04;
    localparam logic [7:0] RSRC_OFF_MASK    = 8'h08;
    localparam logic [7:0] RSRC_OFF_CONV    = 8'h0c;
    localparam logic [7:0] RSRC_OFF_CONV2   = 8'h10;
    localparam logic [7:0] RSRC_OFF_REGCTL  = 8'h14;
    localparam logic [7:0] RSRC_OFF_LINCTL  = 8'h18;
    localparam logic [7:0] RSRC_OFF_STATE   = 8'h1c;
    localparam logic [7:0] RSRC_OFF_BUCK3V  = 8'h20;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          RSRC_LOWRIP_BIT  = 3;
    localparam logic [4:0]  RSRC_MASK_RST    = 5'h00;
    localparam logic [7:0]  RSRC_CONV_RST    = 8'h00;
    localparam logic [2:0]  RSRC_DIS_RST     = 3'h0;
    localparam logic [1:0]  RSRC_REGCTL_RST  = 2'h3;
    localparam logic [7:0]  RSRC_LINCTL_RST  = 8'h00;
    localparam logic [5:0]  RSRC_B3_LOW      = 6'h0d; // 1.3 V in 0.1 V
    localparam logic [5:0]  RSRC_B3_HIGH     = 6'h1f; // 1.55 V in 0.05 V
    localparam logic [31:0] RSRC_UNMAPPED    = 32'h0000_00ff;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int RSRC_CLK_MHZ       = 100;
    localparam int RSRC_DELAY_US      = 170;
    localparam int RSRC_SOFT_US       = 750;
    localparam int RSRC_DEBOUNCE_MS   = 30;
    localparam int RSRC_HOLD_MS_PER_NF = 100;
    localparam int RSRC_DELAY_CYC = RSRC_DELAY_US * RSRC_CLK_MHZ;
    localparam int RSRC_SOFT_CYC  = RSRC_SOFT_US * RSRC_CLK_MHZ;
    localparam int RSRC_DEB_CYC   = RSRC_DEBOUNCE_MS * 1000 * RSRC_CLK_MHZ;
    localparam int RSRC_HOLD_CYC  = RSRC_HOLD_MS_PER_NF * 1000 * RSRC_CLK_MHZ;

    // per-converter start phase
    typedef enum logic [1:0] {
        RSRC_OFF   = 2'b00,
        RSRC_BIAS  = 2'b01,
        RSRC_RAMP  = 2'b10,
        RSRC_RUN   = 2'b11
    } rsrc_phase_t;

    // analog comparator inputs grouped together
    typedef struct packed {
        logic [4:0] out_low;   // below 10 % under target, per rail
        logic [4:0] out_ok;    // above 5 % hysteresis point, per rail
        logic [2:0] precharged;
        logic [2:0] near_drop; // input close to output
    } rsrc_sense_t;

    // per-converter control to the power stage
    typedef struct packed {
        logic [2:0] switching;
        logic [2:0] full_duty;
        logic [2:0] discharge;
        logic [2:0] hold_off;   // no sinking while precharged
        logic [2:0] low_ripple;
    } rsrc_stage_t;

endpackage

// >>> rsrc_top.sv
/*
 * Regulator supervisor and reset control: enables, lockout, start timing,
 * discharge, power-good status and interrupt, warm-reset debounce and
 * system reset hold, with an APB register slave.
 * Assumes all inputs are synchronous to pclk and analog comparators are
 * outside; the reset pin is open drain, resolved by the surroundings.
 */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
module rsrc_top #(
    parameter int DELAY_CYC = rsrc_pkg::RSRC_DELAY_CYC,
    parameter int SOFT_CYC  = rsrc_pkg::RSRC_SOFT_CYC,
    parameter int DEB_CYC   = rsrc_pkg::RSRC_DEB_CYC,
    parameter int HOLD_CYC  = rsrc_pkg::RSRC_HOLD_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 buck1_enable,
    input  wire logic                 buck2_enable,
    input  wire logic                 buck3_enable,
    input  wire logic                 linear_reg_enable_pin,
    input  wire logic                 buck1_default_select,
    input  wire logic                 buck2_default_select,
    input  wire logic                 buck3_default_select,
    input  wire logic                 uvlo,
    input  wire logic                 overtemperature,
    input  wire logic                 rtc_rail_low,
    input  wire logic                 warm_reset_n_in,
    input  wire logic [31:0]          reset_delay_cap_pin,
    input  wire rsrc_pkg::rsrc_sense_t sense,
    output rsrc_pkg::rsrc_stage_t     stage,
    output logic      [4:0]           rail_on,
    output logic      [5:0]           buck3_vsel,
    output logic      [1:0]           buck12_default_hi,
    output logic                      int_n,
    output logic                      system_reset_out_o,
    output logic                      system_reset_out_oe
);

    // every check below runs on pclk and rests during reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // effective enables
    // ****************************************************************
    logic       fault;
    logic [2:0] buck_en;
    logic [1:0] lin_en;
    logic [7:0] conv_q;
    logic [2:0] dis_q;
    logic [1:0] regctl_q;
    logic [7:0] linctl_q;
    logic [4:0] mask_q;
    logic [4:0] block_q;
    logic [4:0] pgood_q;
    logic [5:0] b3v_q;
    logic       deb_q;

    assign fault   = uvlo | overtemperature;
    assign buck_en = {buck3_enable, buck2_enable, buck1_enable} &
                     {3{~fault}};
    assign lin_en  = {2{linear_reg_enable_pin & ~fault}} & regctl_q;

    // ****************************************************************
    // per-converter start sequence
    // ****************************************************************
    rsrc_pkg::rsrc_phase_t phase_q [3];
    logic [31:0]           tmr_q   [3];
    logic [2:0]            pre_q;

    // bias delay then soft ramp; disable aborts at once
    for (genvar i = 0; i < 3; i++) begin : g_conv
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                phase_q[i] <= rsrc_pkg::RSRC_OFF;
                tmr_q[i]   <= 32'h0000_0000;
                pre_q[i]   <= 1'b0;
            end else if (!buck_en[i]) begin
                phase_q[i] <= rsrc_pkg::RSRC_OFF;
                tmr_q[i]   <= 32'h0000_0000;
                pre_q[i]   <= 1'b0;
            end else begin
                case (phase_q[i])
                    rsrc_pkg::RSRC_OFF: phase_q[i] <= rsrc_pkg::RSRC_BIAS;
                    rsrc_pkg::RSRC_BIAS: begin
                        // precharge sampled during the bias delay
                        pre_q[i] <= sense.precharged[i];
                        if (tmr_q[i] >= 32'(DELAY_CYC - 1)) begin
                            phase_q[i] <= rsrc_pkg::RSRC_RAMP;
                            tmr_q[i]   <= 32'h0000_0000;
                        end else begin
                            tmr_q[i] <= tmr_q[i] + 32'h0000_0001;
                        end
                    end
                    rsrc_pkg::RSRC_RAMP: begin
                        // a precharged output ends the ramp when it is met
                        if (tmr_q[i] >= 32'(SOFT_CYC - 1) ||
                            (pre_q[i] && !sense.precharged[i])) begin
                            phase_q[i] <= rsrc_pkg::RSRC_RUN;
                            pre_q[i]   <= 1'b0;
                        end else begin
                            tmr_q[i] <= tmr_q[i] + 32'h0000_0001;
                        end
                    end
                    default: phase_q[i] <= rsrc_pkg::RSRC_RUN;
                endcase
            end
        end
    end

    // ****************************************************************
    // power stage controls, registered
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage   <= '0;
            rail_on <= 5'h00;
        end else begin
            for (int i = 0; i < 3; i++) begin
                stage.switching[i] <= phase_q[i] == rsrc_pkg::RSRC_RAMP ||
                                      phase_q[i] == rsrc_pkg::RSRC_RUN;
                stage.full_duty[i] <= buck_en[i] &&
                                      phase_q[i] == rsrc_pkg::RSRC_RUN &&
                                      sense.near_drop[i];
                stage.hold_off[i]  <= phase_q[i] == rsrc_pkg::RSRC_RAMP &&
                                      pre_q[i];
                stage.discharge[i] <= dis_q[i] & ~buck_en[i];
                stage.low_ripple[i] <= conv_q[rsrc_pkg::RSRC_LOWRIP_BIT];
            end
            rail_on <= {buck_en, lin_en};
        end
    end

    // ****************************************************************
    // power-good status with hysteresis
    // ****************************************************************
    logic [4:0] rail_en;
    assign rail_en = {buck_en, lin_en[1], lin_en[0]};

    // fault bit set below 10 %, cleared above the 5 % point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pgood_q <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (!rail_en[i]) begin
                    pgood_q[i] <= 1'b0;
                end else if (sense.out_low[i]) begin
                    pgood_q[i] <= 1'b1;
                end else if (sense.out_ok[i]) begin
                    pgood_q[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // interrupt with read blocking
    // ****************************************************************
    logic rd_pgood;
    assign rd_pgood = psel & penable & ~pwrite &
                      (paddr == rsrc_pkg::RSRC_OFF_PGOOD);

    // a read blocks bits active then; a cleared fault lifts its block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 5'h00;
        end else begin
            block_q <= (block_q & pgood_q) |
                       (rd_pgood ? pgood_q : 5'h00);
        end
    end

    // active low pin: low while any unmasked unblocked fault stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~|(pgood_q & ~mask_q & ~block_q);
        end
    end

    // ****************************************************************
    // warm-reset debounce
    // ****************************************************************
    logic [31:0] deb_cnt_q;

    // input must stay at a new level a full filter time to be taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deb_q     <= 1'b0;
            deb_cnt_q <= 32'h0000_0000;
        end else if ((~warm_reset_n_in) == deb_q) begin
            deb_cnt_q <= 32'h0000_0000;
        end else if (deb_cnt_q >= 32'(DEB_CYC - 1)) begin
            deb_q     <= ~warm_reset_n_in;
            deb_cnt_q <= 32'h0000_0000;
        end else begin
            deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // system reset hold
    // ****************************************************************
    logic [31:0] hold_q;
    logic        hold_done_q;
    logic [31:0] hold_lim;

    // zero on the capacitor pin means the plain per-nF count
    assign hold_lim = (reset_delay_cap_pin == 32'h0000_0000) ?
                      32'(HOLD_CYC) : reset_delay_cap_pin;

    // rail-low comparator already carries 2.4/2.52 V hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q      <= 32'h0000_0000;
            hold_done_q <= 1'b0;
        end else if (rtc_rail_low || deb_q) begin
            hold_q      <= 32'h0000_0000;
            hold_done_q <= 1'b0;
        end else if (!hold_done_q) begin
            if (hold_q >= hold_lim - 32'h0000_0001) begin
                hold_done_q <= 1'b1;
            end else begin
                hold_q <= hold_q + 32'h0000_0001;
            end
        end
    end

    // open drain: drive low while not released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset_out_oe <= 1'b1;
        end else begin
            system_reset_out_oe <= ~hold_done_q;
        end
    end
    assign system_reset_out_o = 1'b0;

    // ****************************************************************
    // default voltages
    // ****************************************************************
    // reload while system reset is held, so power-up follows the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b3v_q             <= rsrc_pkg::RSRC_B3_LOW;
            buck12_default_hi <= 2'h0;
        end else begin
            buck12_default_hi <= {buck2_default_select,
                                  buck1_default_select};
            if (!hold_done_q || rtc_rail_low || uvlo) begin
                b3v_q <= buck3_default_select ? rsrc_pkg::RSRC_B3_HIGH :
                         rsrc_pkg::RSRC_B3_LOW;
            end else if (psel && penable && pwrite &&
                         paddr == rsrc_pkg::RSRC_OFF_BUCK3V) begin
                b3v_q <= pwdata[5:0];
            end
        end
    end
    assign buck3_vsel = b3v_q;

    // ****************************************************************
    // apb register slave
    // ****************************************************************
    logic wr_acc;
    assign wr_acc = psel & penable & pwrite;

    // writable control registers; warm reset leaves them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_q   <= rsrc_pkg::RSRC_CONV_RST;
            dis_q    <= rsrc_pkg::RSRC_DIS_RST;
            regctl_q <= rsrc_pkg::RSRC_REGCTL_RST;
            linctl_q <= rsrc_pkg::RSRC_LINCTL_RST;
            mask_q   <= rsrc_pkg::RSRC_MASK_RST;
        end else if (wr_acc) begin
            if (paddr == rsrc_pkg::RSRC_OFF_CONV) begin
                conv_q <= pwdata[7:0];
            end else if (paddr == rsrc_pkg::RSRC_OFF_CONV2) begin
                dis_q <= pwdata[2:0];
            end else if (paddr == rsrc_pkg::RSRC_OFF_REGCTL) begin
                regctl_q <= pwdata[1:0];
            end else if (paddr == rsrc_pkg::RSRC_OFF_LINCTL) begin
                linctl_q <= pwdata[7:0];
            end else if (paddr == rsrc_pkg::RSRC_OFF_MASK) begin
                mask_q <= pwdata[4:0];
            end
        end
    end

    // read data registered in the setup cycle, ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (paddr == rsrc_pkg::RSRC_OFF_PGOOD) begin
                prdata <= {27'h0, pgood_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_MASK) begin
                prdata <= {27'h0, mask_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_CONV) begin
                prdata <= {24'h0, conv_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_CONV2) begin
                prdata <= {29'h0, dis_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_REGCTL) begin
                prdata <= {30'h0, regctl_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_LINCTL) begin
                prdata <= {24'h0, linctl_q};
            end else if (paddr == rsrc_pkg::RSRC_OFF_STATE) begin
                prdata <= {26'h0, deb_q, hold_done_q, block_q[3:0]};
            end else if (paddr == rsrc_pkg::RSRC_OFF_BUCK3V) begin
                prdata <= {26'h0, b3v_q};
            end else begin
                prdata <= rsrc_pkg::RSRC_UNMAPPED;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_fault_rails_off: assert property (fault |=> rail_on == 5'h00)
        else $error("rails on during fault");
    chk_disch_when_off: assert property (
        (dis_q[0] && !buck_en[0]) |=> stage.discharge[0])
        else $error("no discharge when off");
    chk_no_early_switch: assert property (
        $rose(buck_en[0]) |=> !stage.switching[0] [*2])
        else $error("switching too early");
    chk_pgood_off_good: assert property (!rail_en[2] |=> !pgood_q[2])
        else $error("disabled rail not good");
    chk_ripple_follow: assert property (
        conv_q[rsrc_pkg::RSRC_LOWRIP_BIT] |=> stage.low_ripple == 3'h7)
        else $error("low ripple not applied");
    sequence s_warm_taken;
        $rose(deb_q);
    endsequence
    chk_warm_reset: assert property (
        s_warm_taken |-> ##2 system_reset_out_oe)
        else $error("warm reset did not pull reset");
    chk_rail_low_rst: assert property (
        rtc_rail_low |=> ##1 system_reset_out_oe)
        else $error("reset released with rail low");
    chk_read_blocks: assert property (
        rd_pgood |=> (block_q & $past(pgood_q)) == $past(pgood_q))
        else $error("read did not block bit");

endmodule
